// [hw/fmt_pkg.sv]
// Constants of the output formatter.
package fmt_pkg;
   // Point word: [19:0] BCD digits, [22:20] digits after point, then flags.
   // Seconds: whole seconds in [19:12], eighths in [2:0].
   localparam int          PT_W         = 28;
   localparam int          B_DP         = 20;
   localparam int          B_SECS       = 23;
   localparam int          B_FIX4       = 24;
   localparam int          B_NEG        = 25;
   localparam int          B_HI         = 26;
   localparam int          B_LAST       = 27;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          SM_COUNT     = 8;
   localparam logic [2:0]  SECS_DP      = 3'h3;
   localparam logic [2:0]  LAST_IN_LINE = 3'h7;
   localparam logic [7:0]  PID_FIRST    = 8'h01;
   localparam logic [7:0]  CH_SP        = 8'h20;
   localparam logic [7:0]  CH_CR        = 8'h0d;
   localparam logic [7:0]  CH_LF        = 8'h0a;
   localparam logic [7:0]  CH_PLUS      = 8'h2b;
   localparam logic [7:0]  CH_MINUS     = 8'h2d;
   localparam logic [7:0]  CH_COMMA     = 8'h2c;
   localparam logic [7:0]  CH_DOT       = 8'h2e;
   localparam logic [7:0]  CH_ZERO      = 8'h30;
   // Device code tens digit; the last two are module address units digits.
   localparam logic [3:0]  DEV_PRN_ADDR = 4'h1;
   localparam logic [3:0]  DEV_CSV_ADDR = 4'h2;
   localparam logic [3:0]  DEV_PRN_PIN  = 4'h4;
   localparam logic [3:0]  DEV_CSV_PIN  = 4'h5;
   localparam logic [3:0]  DEV_SM       = 4'h7;
   localparam logic [3:0]  DEV_AREA     = 4'h8;
   localparam logic [3:0]  UNIV_ADDR    = 4'h1;
   localparam logic [3:0]  SM_ADDR_MAX  = 4'h8;

   // Eighths of a second as BCD fraction digits.
   function automatic logic [11:0] eighths_bcd(input logic [2:0] e);
      logic [11:0] r;
      r = 12'h000;
      unique case (e)
         3'h0: r = 12'h000;
         3'h1: r = 12'h125;
         3'h2: r = 12'h250;
         3'h3: r = 12'h375;
         3'h4: r = 12'h500;
         3'h5: r = 12'h625;
         3'h6: r = 12'h750;
         3'h7: r = 12'h875;
      endcase
      return r;
   endfunction : eighths_bcd
endpackage : fmt_pkg

// [hw/peripheral_output_formatter.sv]
`timescale 1ns/1ps
// Output formatter: module search, fetch and ASCII framing.

// Overview of operation
// RL1: Manual dump refuses codes 80 and 81.
// RL2: Printable point starts with ID and sign.
// RL3: Array ID, day, time print four digits.
// RL4: Seconds shown in eighths of a second.
// RL5: Full printable line holds eight points.
// RL6: High-res ends CRLF; low-res space CRLF.
// RL7: Short lines end like full lines.
// RL8: CSV strips IDs, zeros, points, plus.
// RL9: CSV commas between points, CRLF per array.
// RL10: Module marks file on power return.
// RL11: Module address lies in one to eight.
// RL12: Module resets to address one.
// RL13: Address one picks lowest module, skipping full fill-and-stop ones.
// RL14: Full fill-and-stop module hands over to next lowest.
// RL15: Absent module keeps data and pointer.
// RL16: Present module gets pointer through DSP.
// RL17: Module lamp lit during transfer.
// RL18: Absent module request dropped until next run.
// RL19: One character at a time; arrays whole.
module peripheral_output_formatter #(
   parameter int AW = 16
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          run_pulse,
   input  wire logic [7:0]    run_code,
   input  wire logic [AW-1:0] dsp,
   input  wire logic          dump_pulse,
   input  wire logic [7:0]    dump_code,
   input  wire logic [AW-1:0] dump_first,
   input  wire logic [AW-1:0] dump_last,
   input  wire logic [7:0]    sm_present,
   input  wire logic [7:0]    sm_full,
   input  wire logic [7:0]    sm_fill_stop,
   input  wire logic [27:0]   mem_rd_data,
   input  wire logic          char_ready,
   output logic [AW-1:0]      mem_addr,
   output logic               mem_rd,
   output logic [7:0]         char_data,
   output logic               char_valid,
   output logic [AW-1:0]      module_pointer,
   output logic [2:0]         sm_addr,
   output logic               sm_sel,
   output logic               prn_en,
   output logic               busy,
   output logic               sm_absent,
   output logic               refused,
   output logic               area_copy
);
   localparam int WW = fmt_pkg::PT_W + 1;

   if (AW < 2 || AW > 32) begin : g_bad
      $error("address width must be 2 to 32");
   end

   typedef enum {X_IDLE, X_SEEK, X_FETCH, X_WAIT} xfer_state_t;
   typedef enum {F_IDLE, F_SEP, F_ID1, F_ID2, F_SIGN, F_VAL, F_PAD, F_CR, F_LF} fmt_state_t;

   word_if #(.W(WW)) wq ();

   word_fifo #(.WIDTH(WW), .DEPTH(fmt_pkg::FIFO_DEPTH)) u_fifo (
      .clk    (clk),
      .resetn (resetn),
      .port   (wq.store)
   );

   // Request decode and module search.
   xfer_state_t   x_reg;
   logic [AW-1:0] loc_reg;
   logic [AW-1:0] end_reg;
   logic [AW-1:0] prn_ptr_reg;
   logic [7:0]    want_reg;
   logic          csv_reg;
   logic          online_reg;
   logic          univ_reg;
   logic          req_go;
   logic [7:0]    req_code;
   logic          req_ok;
   logic          req_csv;
   logic          req_pin;
   logic          req_sm;
   logic [7:0]    cand;
   logic [2:0]    cand_idx;
   logic [AW-1:0] req_start;
   logic [AW-1:0] req_end;
   logic [3:0]    req_n;

   always_comb begin
      req_go   = (run_pulse || dump_pulse) && x_reg == X_IDLE;
      req_code = run_pulse ? run_code : dump_code;
      req_n    = req_code[3:0];
      req_ok   = 1'b0;
      req_csv  = 1'b0;
      req_pin  = 1'b0;
      req_sm   = 1'b0;
      unique case (req_code[7:4])
         fmt_pkg::DEV_PRN_ADDR: req_ok = 1'b1;
         fmt_pkg::DEV_CSV_ADDR: begin
            req_ok  = 1'b1;
            req_csv = 1'b1;
         end
         fmt_pkg::DEV_PRN_PIN: begin
            req_ok  = 1'b1;
            req_pin = 1'b1;
         end
         fmt_pkg::DEV_CSV_PIN: begin
            req_ok  = 1'b1;
            req_pin = 1'b1;
            req_csv = 1'b1;
         end
         fmt_pkg::DEV_SM: begin
            req_sm = 1'b1;
            req_ok = req_n >= fmt_pkg::UNIV_ADDR && req_n <= fmt_pkg::SM_ADDR_MAX; // RL11
         end
         default: req_ok = 1'b0;
      endcase
      req_start = run_pulse ? (req_sm ? module_pointer : prn_ptr_reg) : dump_first;
      req_end   = run_pulse ? dsp : dump_last + 1'b1;
      // Fill-and-stop modules that are full are passed over.
      cand      = sm_present & ~(sm_full & sm_fill_stop) & want_reg; // RL13
      cand_idx  = 3'h0;
      for (int i = fmt_pkg::SM_COUNT - 1; i >= 0; i--) begin
         if (cand[i]) begin
            cand_idx = 3'(i);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         x_reg          <= X_IDLE;
         loc_reg        <= '0;
         end_reg        <= '0;
         prn_ptr_reg    <= '0;
         module_pointer <= '0;
         want_reg       <= 8'h00;
         csv_reg        <= 1'b0;
         online_reg     <= 1'b0;
         univ_reg       <= 1'b0;
         mem_addr       <= '0;
         mem_rd         <= 1'b0;
         sm_addr        <= 3'h0;
         sm_sel         <= 1'b0;
         prn_en         <= 1'b0;
         busy           <= 1'b0;
         sm_absent      <= 1'b0;
         refused        <= 1'b0;
         area_copy      <= 1'b0;
      end else begin
         mem_rd    <= 1'b0;
         sm_absent <= 1'b0;
         refused   <= 1'b0;
         area_copy <= 1'b0;
         unique case (x_reg)
            X_IDLE: begin
               if (req_go && run_pulse && req_code[7:4] == fmt_pkg::DEV_AREA) begin
                  area_copy <= 1'b1;
               end else if (req_go && !req_ok) begin
                  refused <= 1'b1; // RL1
               end else if (req_go && req_start != req_end) begin // RL15
                  loc_reg    <= req_start;
                  end_reg    <= req_end;
                  csv_reg    <= req_csv;
                  online_reg <= run_pulse;
                  univ_reg   <= req_n == fmt_pkg::UNIV_ADDR;
                  want_reg   <= req_n == fmt_pkg::UNIV_ADDR ? 8'hff : 8'h01 << (req_n - 4'h1);
                  prn_en     <= req_pin;
                  busy       <= 1'b1;
                  x_reg      <= req_sm ? X_SEEK : X_FETCH;
               end
            end
            X_SEEK: begin
               if (|cand) begin
                  sm_addr <= cand_idx; // RL13
                  sm_sel  <= 1'b1;
                  x_reg   <= X_FETCH;
               end else begin
                  sm_absent <= 1'b1; // RL15
                  sm_sel    <= 1'b0;
                  busy      <= 1'b0;
                  x_reg     <= X_IDLE; // RL18
               end
            end
            X_FETCH: begin
               if (sm_sel && univ_reg && sm_full[sm_addr] && sm_fill_stop[sm_addr]) begin
                  sm_sel <= 1'b0;
                  x_reg  <= X_SEEK; // RL14
               end else if (loc_reg == end_reg) begin
                  sm_sel <= 1'b0;
                  prn_en <= 1'b0;
                  busy   <= 1'b0;
                  x_reg  <= X_IDLE;
               end else if (wq.in_ready) begin
                  mem_addr <= loc_reg;
                  mem_rd   <= 1'b1;
                  x_reg    <= X_WAIT;
               end
            end
            X_WAIT: begin
               loc_reg <= loc_reg + 1'b1; // RL16
               if (online_reg && sm_sel) begin
                  module_pointer <= loc_reg + 1'b1;
               end
               if (online_reg && !sm_sel) begin
                  prn_ptr_reg <= loc_reg + 1'b1;
               end
               x_reg <= X_FETCH;
            end
         endcase
      end
   end

   // Room was checked before the read, so the push is always taken.
   assign wq.in_valid = x_reg == X_WAIT;
   assign wq.in_data  = {csv_reg, mem_rd_data};

   // Point text building.
   fmt_state_t     f_reg;
   fmt_state_t     f_next;
   logic [WW-1:0]  w_reg;
   logic [2:0]     vi_reg;
   logic [7:0]     pid_reg;
   logic [2:0]     line_reg;
   logic           fresh_reg;
   logic           adv;
   logic           csv;
   logic           hi;
   logic           dotted;
   logic [2:0]     nd;
   logic [2:0]     dpos;
   logic [2:0]     vlen;
   logic [2:0]     vfirst;
   logic [2:0]     vlast;
   logic [2:0]     vend;
   logic [19:0]    dig;
   logic [3:0]     dg [5];
   logic [7:0]     vch [6];
   logic           eol;
   logic [7:0]     ch;
   logic           emit;
   logic           pt_done;

   always_comb begin
      int j;
      j      = 0;
      csv    = w_reg[fmt_pkg::PT_W];
      hi     = (w_reg[fmt_pkg::B_HI] || w_reg[fmt_pkg::B_SECS]) && !w_reg[fmt_pkg::B_FIX4]; // RL3
      dotted = !w_reg[fmt_pkg::B_FIX4];
      nd     = hi ? 3'h5 : 3'h4;
      dig    = w_reg[fmt_pkg::B_SECS] ?
               {w_reg[19:12], fmt_pkg::eighths_bcd(w_reg[2:0])} : w_reg[19:0]; // RL4
      dpos   = nd - (w_reg[fmt_pkg::B_SECS] ? fmt_pkg::SECS_DP : w_reg[fmt_pkg::B_DP +: 3]);
      if (!w_reg[fmt_pkg::B_SECS] && w_reg[fmt_pkg::B_DP +: 3] > nd) begin
         dpos = 3'h0;
      end
      vlen = nd + {2'h0, dotted};
      for (int i = 0; i < 5; i++) begin
         dg[i] = hi ? dig[16 - 4 * i +: 4] : (i < 4 ? dig[12 - 4 * i +: 4] : 4'h0);
      end
      for (int k = 0; k < 6; k++) begin
         j = (dotted && 3'(k) > dpos) ? k - 1 : k;
         if (j > 4) begin
            j = 4;
         end
         vch[k] = (dotted && 3'(k) == dpos) ? fmt_pkg::CH_DOT : fmt_pkg::CH_ZERO | {4'h0, dg[j]};
      end
      // Leading zeros go except the one before the point; trailing ones after a point too.
      vfirst = 3'h0;
      for (int k = 0; k < 5; k++) begin
         if (3'(k) == vfirst && 3'(k) < vlen - 3'h1 && vch[k] == fmt_pkg::CH_ZERO
             && vch[k + 1] != fmt_pkg::CH_DOT) begin
            vfirst = 3'(k + 1); // RL8
         end
      end
      vlast = vlen - 3'h1;
      for (int k = 5; k > 0; k--) begin
         if (dotted && 3'(k) == vlast && vch[k] == fmt_pkg::CH_ZERO) begin
            vlast = 3'(k - 1); // RL8
         end
      end
      if (vch[vlast] == fmt_pkg::CH_DOT && vlast > vfirst) begin
         vlast = vlast - 3'h1; // RL8
      end
      vend = csv ? vlast : vlen - 3'h1;
   end

   // Character emission.
   assign adv          = !char_valid || char_ready; // RL19
   assign wq.out_ready = f_reg == F_IDLE && adv;
   assign eol          = w_reg[fmt_pkg::B_LAST] || line_reg == fmt_pkg::LAST_IN_LINE; // RL5 RL7

   always_comb begin
      ch     = fmt_pkg::CH_SP;
      emit   = 1'b0;
      f_next = f_reg;
      unique case (f_reg)
         F_IDLE: begin
            if (wq.out_valid) begin
               f_next = fresh_reg ? (wq.out_data[fmt_pkg::PT_W] ? F_SIGN : F_ID1) : F_SEP;
            end
         end
         F_SEP: begin
            emit   = 1'b1;
            ch     = csv ? fmt_pkg::CH_COMMA : fmt_pkg::CH_SP; // RL9
            f_next = csv ? F_SIGN : F_ID1;
         end
         F_ID1: begin
            emit   = 1'b1;
            ch     = fmt_pkg::CH_ZERO | {4'h0, pid_reg[7:4]}; // RL2
            f_next = F_ID2;
         end
         F_ID2: begin
            emit   = 1'b1;
            ch     = fmt_pkg::CH_ZERO | {4'h0, pid_reg[3:0]}; // RL2
            f_next = F_SIGN;
         end
         F_SIGN: begin
            emit   = !csv || w_reg[fmt_pkg::B_NEG]; // RL8
            ch     = w_reg[fmt_pkg::B_NEG] ? fmt_pkg::CH_MINUS : fmt_pkg::CH_PLUS; // RL2
            f_next = F_VAL;
         end
         F_VAL: begin
            emit = 1'b1;
            ch   = vch[vi_reg];
            if (vi_reg == vend) begin
               if (csv) begin
                  f_next = w_reg[fmt_pkg::B_LAST] ? F_CR : F_IDLE; // RL9
               end else if (!hi) begin
                  f_next = F_PAD; // RL6
               end else begin
                  f_next = eol ? F_CR : F_IDLE; // RL6
               end
            end
         end
         F_PAD: begin
            emit   = 1'b1;
            f_next = eol ? F_CR : F_IDLE; // RL6
         end
         F_CR: begin
            emit   = 1'b1;
            ch     = fmt_pkg::CH_CR;
            f_next = F_LF;
         end
         F_LF: begin
            emit   = 1'b1;
            ch     = fmt_pkg::CH_LF;
            f_next = F_IDLE;
         end
      endcase
   end

   assign pt_done = (f_reg == F_VAL || f_reg == F_PAD) && (f_next == F_IDLE || f_next == F_CR);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         f_reg      <= F_IDLE;
         char_valid <= 1'b0;
         char_data  <= 8'h00;
         w_reg      <= '0;
         vi_reg     <= 3'h0;
      end else if (adv) begin
         f_reg      <= f_next;
         char_valid <= emit; // RL19
         if (emit) begin
            char_data <= ch;
         end
         if (wq.out_valid && wq.out_ready) begin
            w_reg <= wq.out_data;
         end
         if (f_reg == F_SIGN) begin
            vi_reg <= csv ? vfirst : 3'h0;
         end else if (f_reg == F_VAL && vi_reg != vend) begin
            vi_reg <= vi_reg + 3'h1;
         end
      end
   end

   // Line and point numbering.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pid_reg   <= fmt_pkg::PID_FIRST;
         line_reg  <= 3'h0;
         fresh_reg <= 1'b1;
      end else if (adv) begin
         if (pt_done) begin
            fresh_reg <= 1'b0;
            line_reg  <= line_reg + 3'h1; // RL5
            pid_reg   <= pid_reg[3:0] == 4'h9 ? {pid_reg[7:4] + 4'h1, 4'h0} : pid_reg + 8'h01;
         end
         if (f_reg == F_LF) begin
            fresh_reg <= 1'b1;
            line_reg  <= 3'h0;
            if (w_reg[fmt_pkg::B_LAST]) begin
               pid_reg <= fmt_pkg::PID_FIRST;
            end
         end
      end
   end
endmodule : peripheral_output_formatter

// [hw/word_fifo.sv]
`timescale 1ns/1ps
// Flip-flop FIFO with valid/ready on both sides.
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   word_if.store    port
);
   localparam int AB = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("word_fifo needs a power-of-two depth of at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AB:0]      wr_reg;
   logic [AB:0]      rd_reg;
   logic             push;
   logic             pop;

   assign port.in_ready  = !((wr_reg[AB] != rd_reg[AB]) && (wr_reg[AB-1:0] == rd_reg[AB-1:0]));
   assign port.out_valid = wr_reg != rd_reg;
   assign port.out_data  = mem_reg[rd_reg[AB-1:0]];
   assign push           = port.in_valid && port.in_ready;
   assign pop            = port.out_valid && port.out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg[AB-1:0]] <= port.in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule : word_fifo

// [hw/word_if.sv]
`timescale 1ns/1ps
// Valid/ready word channel through the FIFO.
interface word_if #(parameter int W = 8);
   logic [W-1:0] in_data;
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] out_data;
   logic         out_valid;
   logic         out_ready;
   modport fill  (output in_data, in_valid, input in_ready);
   modport drain (input out_data, out_valid, output out_ready);
   modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
endinterface : word_if

// [tb/peripheral_output_formatter_props.sv]
// Checker of the formatter's ports.
`timescale 1ns/1ps
module peripheral_output_formatter_props #(
   parameter int AW = 16
) (
   input wire logic          clk,
   input wire logic          resetn,
   input wire logic          run_pulse,
   input wire logic [7:0]    run_code,
   input wire logic [AW-1:0] dsp,
   input wire logic          dump_pulse,
   input wire logic [7:0]    dump_code,
   input wire logic [7:0]    sm_present,
   input wire logic [7:0]    sm_full,
   input wire logic [7:0]    sm_fill_stop,
   input wire logic          char_ready,
   input wire logic [7:0]    char_data,
   input wire logic          char_valid,
   input wire logic [AW-1:0] module_pointer,
   input wire logic [2:0]    sm_addr,
   input wire logic          sm_sel,
   input wire logic          busy,
   input wire logic          sm_absent,
   input wire logic          refused,
   input wire logic          area_copy
);
   logic       univ;
   logic [7:0] elig;
   logic [2:0] low;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   assign elig = sm_present & ~(sm_full & sm_fill_stop);

   always_comb begin
      low = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (elig[i]) begin
            low = 3'(i);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         univ <= 1'b0;
      end else if ((run_pulse || dump_pulse) && !busy) begin
         univ <= run_pulse ? (run_code == 8'h71) : (dump_code == 8'h71);
      end
   end

   AST_DUMP_AREA: assert property (
      dump_pulse && !run_pulse && !busy && dump_code[7:4] == 4'h8 |=> refused)
      else $error("dump took area code");
   AST_RUN_AREA: assert property (
      run_pulse && !busy && run_code[7:4] == 4'h8 |=> area_copy && !refused)
      else $error("no area copy");
   AST_ABSENT: assert property (
      run_pulse && !busy && run_code == 8'h71 && sm_present == 8'h00
      && module_pointer != dsp |-> ##2 sm_absent)
      else $error("absence not flagged");
   AST_PTR_KEPT: assert property (
      sm_absent |-> $stable(module_pointer) ##1 $stable(module_pointer))
      else $error("pointer moved");
   AST_PTR_STEP: assert property (
      module_pointer != $past(module_pointer)
      |-> module_pointer == $past(module_pointer) + 1'b1)
      else $error("pointer skipped");
   AST_UNIV: assert property (
      $rose(sm_sel) && univ |-> sm_addr == low)
      else $error("wrong module chosen");
   AST_SEL_OK: assert property (
      sm_sel |-> sm_present[sm_addr])
      else $error("module absent");
   AST_HOLD: assert property (
      char_valid && !char_ready |=> char_valid && $stable(char_data))
      else $error("char not held");
   AST_CRLF: assert property (
      char_valid && char_ready && char_data == fmt_pkg::CH_CR
      |-> ##[1:3] (char_valid && char_data == fmt_pkg::CH_LF))
      else $error("CR without LF");
   AST_BUSY_IGN: assert property (
      busy && run_pulse |=> !refused && !area_copy)
      else $error("busy request answered");

   COV_AREA: cover property (area_copy);
   COV_ABSENT: cover property (sm_absent);
   COV_SEL: cover property ($rose(sm_sel) && univ);
   COV_STALL: cover property (char_valid && !char_ready ##1 char_ready);
endmodule : peripheral_output_formatter_props

bind peripheral_output_formatter peripheral_output_formatter_props #(.AW(AW)) u_props (
   .clk, .resetn, .run_pulse, .run_code, .dsp, .dump_pulse, .dump_code, .sm_present,
   .sm_full, .sm_fill_stop, .char_ready, .char_data, .char_valid, .module_pointer,
   .sm_addr, .sm_sel, .busy, .sm_absent, .refused, .area_copy);

// [tb/storage_peer.sv]
// Far-side model: character sink and storage modules.
`timescale 1ns/1ps
module storage_peer (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       slow,
   input  wire logic [7:0] plug,
   input  wire logic [7:0] fill_cfg,
   input  wire logic [7:0] char_data,
   input  wire logic       char_valid,
   input  wire logic       sm_sel,
   input  wire logic [2:0] sm_addr,
   output logic            char_ready,
   output logic [7:0]      sm_present,
   output logic [7:0]      sm_fill_stop,
   output logic            lamp
);
   logic [7:0] rx [$];
   logic [7:0] plug_q;
   logic [7:0] last_fm;

   // Slot i is the module at address i+1.
   assign sm_present   = plug;
   assign sm_fill_stop = fill_cfg;
   assign lamp         = sm_sel && plug[sm_addr];

   // Slow mode toggles readiness every cycle.
   always @(posedge clk) begin
      if (char_valid && char_ready) begin
         rx.push_back(char_data);
      end
      #1 char_ready = resetn && (!slow || !char_ready);
   end

   // Power return sets a file mark unless one is last.
   always @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (plug[i] && !plug_q[i]) begin
            last_fm[i] = 1'b1;
         end
      end
      if (char_valid && char_ready && sm_sel) begin
         last_fm[sm_addr] = 1'b0;
      end
      plug_q = plug;
   end
endmodule : storage_peer

// [tb/tb_peripheral_output_formatter.sv]
// Bench of the output formatter.
`timescale 1ns/1ps
module tb_peripheral_output_formatter;
   localparam string CRLF = "\015\012";
   logic        clk, resetn, run_pulse, dump_pulse, slow, mem_rd, char_valid, char_ready;
   logic        sm_sel, prn_en, busy, sm_absent, refused, area_copy;
   logic [7:0]  run_code, dump_code, plug, fill_cfg, sm_full, sm_present, sm_fill_stop;
   logic [7:0]  char_data;
   logic [15:0] dsp, dump_first, dump_last, mem_addr, module_pointer;
   logic [27:0] mem [0:31];
   logic [27:0] rd_q;
   logic [2:0]  sm_addr;
   logic [3:0]  seen;
   int          n_errors, checked, n_ref, n_ac, n_abs, cyc;

   peripheral_output_formatter u_dut (.clk, .resetn, .run_pulse, .run_code, .dsp,
      .dump_pulse, .dump_code, .dump_first, .dump_last, .sm_present, .sm_full,
      .sm_fill_stop, .mem_rd_data(rd_q), .char_ready, .mem_addr, .mem_rd, .char_data,
      .char_valid, .module_pointer, .sm_addr, .sm_sel, .prn_en, .busy, .sm_absent,
      .refused, .area_copy);
   storage_peer u_peer (.clk, .resetn, .slow, .plug, .fill_cfg, .char_data, .char_valid,
      .sm_sel, .sm_addr, .char_ready, .sm_present, .sm_fill_stop, .lamp());

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   assign rd_q = mem_rd ? mem[mem_addr[4:0]] : 'x;

   always @(posedge clk) begin
      n_ref <= n_ref + int'(refused);
      n_ac  <= n_ac + int'(area_copy);
      n_abs <= n_abs + int'(sm_absent);
      cyc = cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         end_sim();
      end
   end

   function automatic string tail();
      string s;
      s = "";
      for (int i = 1; i < 10; i++) begin
         s = {s, (i == 9) ? CRLF : (i > 1) ? " " : "", $sformatf("0%0d+0000%0d.", i, i)};
      end
      return {s, CRLF};
   endfunction : tail

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic chk_str(input string s);
      for (int i = 0; i < s.len(); i++) begin
         chk((u_peer.rx.size() > i) ? u_peer.rx[i] : 8'hxx, s[i]);
      end
      chk(u_peer.rx.size(), s.len());
      u_peer.rx.delete();
   endtask : chk_str

   // Waits for 8 quiet cycles.
   task automatic settle();
      int q;
      q = 0;
      for (int k = 0; k < 3000 && q < 8; k++) begin
         @(posedge clk);
         #1;
         q = (busy || char_valid) ? 0 : q + 1;
         if (sm_sel || prn_en) begin
            seen = {prn_en, sm_addr};
         end
      end
   endtask : settle

   task automatic req(input logic d, input logic [7:0] c);
      @(posedge clk);
      #1;
      run_pulse  = !d;
      dump_pulse = d;
      run_code   = c;
      dump_code  = c;
      @(posedge clk);
      #1;
      run_pulse  = 1'b0;
      dump_pulse = 1'b0;
      settle();
   endtask : req

   task automatic t_codes();
      logic [7:0] bad [6] = '{8'h30, 8'h60, 8'h90, 8'h70, 8'h79, 8'h03};
      int         r0;
      r0 = n_ref;
      foreach (bad[i]) begin
         req(1'b0, bad[i]);
      end
      req(1'b1, 8'h80);
      req(1'b1, 8'h81);
      chk(n_ref - r0, 8);
      r0 = n_ac;
      req(1'b0, 8'h80);
      req(1'b0, 8'h81);
      chk(n_ac - r0, 2);
      chk_str("");
   endtask : t_codes

   task automatic t_prn();
      slow = 1'b1;
      dsp  = 16'h000a;
      fork
         req(1'b0, 8'h10);
         #30 {run_pulse, run_code} = 9'h180;
         #40 run_pulse = 1'b0;
      join
      chk_str({"01-123.45", CRLF, tail()});
      slow = 1'b0;
   endtask : t_prn

   task automatic t_dump();
      dump_first = 16'h000a;
      dump_last  = 16'h000c;
      req(1'b1, 8'h40);
      chk_str({"01+12.34 ", CRLF, "01+0234 ", CRLF, "01+12.375", CRLF});
      chk(seen, 4'h8);
      dump_first = 16'h000d;
      dump_last  = 16'h0011;
      req(1'b1, 8'h20);
      chk_str({"234,1.23,-12.5,0.5,1", CRLF});
   endtask : t_dump

   task automatic t_sm();
      int a0;
      a0  = n_abs;
      dsp = 16'h0001;
      req(1'b0, 8'h71);
      chk(n_abs - a0, 1);
      chk(module_pointer, 16'h0000);
      chk_str("");
      plug     = 8'h05;
      sm_full  = 8'h01;
      fill_cfg = 8'hff;
      req(1'b0, 8'h71);
      chk(seen, 4'h2);
      chk(module_pointer, 16'h0001);
      chk_str({"01-123.45", CRLF});
      fill_cfg = 8'h00;
      dsp      = 16'h000a;
      req(1'b0, 8'h71);
      chk(seen, 4'h0);
      chk(module_pointer, 16'h000a);
      chk_str(tail());
   endtask : t_sm

   task automatic end_sim();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      {resetn, run_pulse, dump_pulse, slow} = 4'h0;
      {run_code, dump_code, plug, fill_cfg, sm_full} = 40'h0;
      {dsp, dump_first, dump_last} = 48'h0;
      {n_errors, checked, n_ref, n_ac, n_abs, cyc} = '0;
      mem[0] = {5'b11100, 3'h2, 20'h12345};
      for (int i = 1; i < 10; i++) begin
         mem[i] = {(i == 9) ? 5'b11000 : 5'b01000, 3'h0, 20'(i)};
      end
      mem[10] = {5'b10000, 3'h2, 20'h01234};
      mem[11] = {5'b10010, 3'h0, 20'h00234};
      mem[12] = {5'b11001, fmt_pkg::SECS_DP, 20'h12003};
      mem[13] = {5'b00010, 3'h0, 20'h00234};
      mem[14] = {5'b01000, 3'h2, 20'h00123};
      mem[15] = {5'b00100, 3'h2, 20'h01250};
      mem[16] = {5'b01000, 3'h2, 20'h00050};
      mem[17] = {5'b11000, 3'h2, 20'h00100};
      repeat (6) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk({busy, char_valid, sm_sel, module_pointer}, 32'h0);
      dsp = 16'h0001;
      t_codes();
      t_prn();
      t_dump();
      t_sm();
      end_sim();
   end
endmodule : tb_peripheral_output_formatter
